/* File: rtl/cfg_map.svh */
// Register map, field positions, reset values and counts of the configuration block
// Functional notes
// - Tx/Rx bit 27 of register 0 selects mode and drives antenna switch.
// - Sequencer clock divides the crystal and paces the digital receive block.
// - Demodulator modes 1, 3, 4, 5 tolerate run lengths above seven bits.
// - Sync detection active only when register 4 bits 25:23 are 010 or 011.
// - Sync register holds a 24-bit pattern compared with demodulated bits.
// - In receive with sync mode, lock rises on match, falls nine bits later.
// - Each write with register 6 bit 19 high starts a filter calibration.
// - With reduced gain bit set, gain control never picks the top step.
// - Top amplifier gain step only selectable while register 6 bit 15 is 0.
// - Unwritten gain thresholds default to low 30 and high 70.
// - Signal strength readback valid in receive only; others blocked with AGC.
// - In transmit, converter readback valid only if log amp not powered down.
// - Register 8 bit 12 resets to 0; setting it selects a shared matching network.
// - Serial data shifts in MSB first on each rising serial clock edge.
// - Load strobe rise copies the word to latch chosen by bits 3:0.
`ifndef CFG_MAP_SVH
`define CFG_MAP_SVH
`define LATCH_COUNT 4'hB
`define IDX_N 4'h0
`define IDX_CLKS 4'h3
`define IDX_DEMOD 4'h4
`define IDX_SYNC 4'h5
`define IDX_CORR 4'h6
`define IDX_RDBK 4'h7
`define IDX_PWR 4'h8
`define IDX_AGC 4'h9
`define IDX_STATUS 4'hF
`define TXRX_BIT 27
`define SEQ_DIV_HI 15
`define SEQ_DIV_LO 8
`define DMODE_HI 6
`define DMODE_LO 4
`define SYNC_MODE_HI 25
`define SYNC_MODE_LO 23
`define SYNC_PAT_HI 27
`define SYNC_PAT_LO 4
`define CAL_BIT 19
`define AMP_RED_BIT 15
`define RB_EN_BIT 8
`define RB_SRC_HI 5
`define RB_SRC_LO 4
`define LOGAMP_PD_BIT 10
`define SHARED_MATCH_BIT 12
`define LOW_THR_HI 10
`define LOW_THR_LO 4
`define HIGH_THR_HI 17
`define HIGH_THR_LO 11
`define AGC_EN_BIT 18
`define LOW_THR_RESET 7'h1E
`define HIGH_THR_RESET 7'h46
`define AGC_RESET 32'h000631E9
`define SYNC_MODE_A 3'h2
`define SYNC_MODE_B 3'h3
`define LOCK_BITS 4'h9
`define CAL_CYCLES 16'h0400
`define GAIN_TOP 2'h3
`define GAIN_REDUCED_TOP 2'h2
`endif

/* File: rtl/cfg_pkg.sv */
// Shared types of the transceiver configuration block
package cfg_pkg;
    typedef struct packed {
        logic wr;
        logic [3:0] idx;
        logic [31:0] data;
    } cfg_word_t;
    typedef struct packed {
        logic en;
        logic [3:0] idx;
        logic [31:0] ext;
    } cfg_read_t;
    typedef enum logic {
        CAL_IDLE,
        CAL_RUN
    } cal_state_t;
    typedef enum logic [1:0] {
        RB_RSSI,
        RB_BATT,
        RB_TEMP,
        RB_PIN
    } rb_src_t;
endpackage

/* File: rtl/cfg_latch_mem.sv */
// Configuration latch store with a registered read port
`timescale 1ns/1ps
`include "cfg_map.svh"
module cfg_latch_mem (
    input logic clk,
    input logic rst_n,
    input logic ce,
    input cfg_pkg::cfg_word_t wr,
    input cfg_pkg::cfg_read_t rd,
    output logic [31:0] rdata
);
    logic [31:0] word_q [11];
    logic [31:0] hit_word;
    wire rd_hit = rd.idx < `LATCH_COUNT;
    assign hit_word = rd_hit ? word_q[rd.idx] : rd.ext;
    genvar i;
    generate
        for (i = 0; i < 11; i++)
        begin : g_word
            localparam logic [31:0] RST = (i == 9) ? `AGC_RESET : {28'h0000000, 4'(i)};
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    word_q[i] <= RST;
                else if (ce && wr.wr && wr.idx == 4'(i))
                    word_q[i] <= wr.data;
            end
        end
    endgenerate
    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 32'h00000000;
        else if (ce)
            rdata <= rd.en ? hit_word : 32'h00000000;
    end
endmodule

/* File: rtl/sync_detect.sv */
// Sync pattern correlator with a nine bit lock pulse
`timescale 1ns/1ps
`include "cfg_map.svh"
module sync_detect (
    input logic clk,
    input logic rst_n,
    input logic ce,
    input logic enable,
    input logic bit_in,
    input logic bit_valid,
    input logic [23:0] pattern,
    output logic lock
);
    logic [23:0] hist_q;
    logic [23:0] hist_d;
    logic [3:0] cnt_q;
    // newest bit at the bottom, first bit reaches the top
    assign hist_d = {hist_q[22:0], bit_in};
    wire match = hist_d == pattern;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hist_q <= 24'h000000;
            cnt_q <= 4'h0;
            lock <= 1'b0;
        end
        else if (ce)
        begin
            if (bit_valid)
                hist_q <= hist_d;
            // rise on match, fall nine bits later
            if (!enable)
                lock <= 1'b0;
            else if (bit_valid && lock)
            begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q + 4'h1 == `LOCK_BITS)
                    lock <= 1'b0;
            end
            else if (bit_valid && match)
            begin
                lock <= 1'b1;
                cnt_q <= 4'h0;
            end
        end
    end
endmodule

/* File: rtl/xcvr_cfg.sv */
// Configuration register bank of the FSK transceiver with serial load and register port
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "cfg_map.svh"
module xcvr_cfg (
    input logic CLK,
    input logic RESET_N,
    input logic CE,
    input logic SCLK,
    input logic SDATA,
    input logic LOAD_STROBE,
    input logic [3:0] ADDR,
    input logic [31:0] WR_DATA,
    input logic WR_EN,
    input logic RD_EN,
    output logic [31:0] RD_DATA,
    input logic RX_BIT,
    input logic RX_BIT_VALID,
    input logic [6:0] RSSI_LEVEL,
    output logic TX_MODE,
    output logic ANT_SWITCH_TX,
    output logic LOCK_INT,
    output logic SYNC_ACTIVE,
    output logic RUNLENGTH_TOLERANT,
    output logic FILTER_CAL_START,
    output logic FILTER_CAL_BUSY,
    output logic SEQUENCER_TICK,
    output logic [1:0] LNA_GAIN,
    output logic READBACK_VALID,
    output logic LOG_AMP_ON,
    output logic SHARED_MATCH
);
    function automatic logic latch_hit(input logic [3:0] idx);
        return idx < `LATCH_COUNT;
    endfunction

    function automatic logic sync_mode(input logic [2:0] m);
        return (m == `SYNC_MODE_A) || (m == `SYNC_MODE_B);
    endfunction

    // Serial capture
    logic sclk_q;
    logic load_q;
    logic [31:0] shift_q;
    wire sclk_rise = SCLK && !sclk_q;
    wire load_rise = LOAD_STROBE && !load_q;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sclk_q <= 1'b0;
            load_q <= 1'b0;
            shift_q <= 32'h00000000;
        end
        else if (CE)
        begin
            sclk_q <= SCLK;
            load_q <= LOAD_STROBE;
            if (sclk_rise)
                shift_q <= {shift_q[30:0], SDATA};
        end
    end

    // Write arbitration: a serial load wins over a port write in the same cycle
    // latch chosen by control bits
    wire ser_load = load_rise && latch_hit(shift_q[3:0]);
    wire bus_load = WR_EN && latch_hit(ADDR);
    cfg_pkg::cfg_word_t wr_word;
    assign wr_word.wr = ser_load || bus_load;
    assign wr_word.idx = ser_load ? shift_q[3:0] : ADDR;
    assign wr_word.data = ser_load ? shift_q : WR_DATA;

    wire wr_n = wr_word.wr && wr_word.idx == `IDX_N;
    wire wr_clks = wr_word.wr && wr_word.idx == `IDX_CLKS;
    wire wr_demod = wr_word.wr && wr_word.idx == `IDX_DEMOD;
    wire wr_sync = wr_word.wr && wr_word.idx == `IDX_SYNC;
    wire wr_corr = wr_word.wr && wr_word.idx == `IDX_CORR;
    wire wr_rdbk = wr_word.wr && wr_word.idx == `IDX_RDBK;
    wire wr_pwr = wr_word.wr && wr_word.idx == `IDX_PWR;
    wire wr_agc = wr_word.wr && wr_word.idx == `IDX_AGC;
    wire [31:0] wd = wr_word.data;

    // Shadow copies of the fields that steer logic
    logic tx_q;
    logic [7:0] seq_div_q;
    logic [2:0] dmode_q;
    logic [2:0] sync_mode_q;
    logic [23:0] sync_pat_q;
    logic amp_red_q;
    logic rb_en_q;
    cfg_pkg::rb_src_t rb_src_q;
    logic logamp_pd_q;
    logic shared_q;
    logic [6:0] low_thr_q;
    logic [6:0] high_thr_q;
    logic agc_en_q;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tx_q <= 1'b0;
            seq_div_q <= 8'h00;
        end
        else if (CE)
        begin
            if (wr_n)
                tx_q <= wd[`TXRX_BIT];
            if (wr_clks)
                seq_div_q <= wd[`SEQ_DIV_HI:`SEQ_DIV_LO];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            dmode_q <= 3'h0;
            sync_mode_q <= 3'h0;
            sync_pat_q <= 24'h000000;
        end
        else if (CE)
        begin
            if (wr_demod)
            begin
                dmode_q <= wd[`DMODE_HI:`DMODE_LO];
                sync_mode_q <= wd[`SYNC_MODE_HI:`SYNC_MODE_LO];
            end
            if (wr_sync)
                sync_pat_q <= wd[`SYNC_PAT_HI:`SYNC_PAT_LO];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            amp_red_q <= 1'b0;
            rb_en_q <= 1'b0;
            rb_src_q <= cfg_pkg::RB_RSSI;
        end
        else if (CE)
        begin
            if (wr_corr)
                amp_red_q <= wd[`AMP_RED_BIT];
            if (wr_rdbk)
            begin
                rb_en_q <= wd[`RB_EN_BIT];
                rb_src_q <= cfg_pkg::rb_src_t'(wd[`RB_SRC_HI:`RB_SRC_LO]);
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            logamp_pd_q <= 1'b0;
            // shared match bit clears at reset
            shared_q <= 1'b0;
            low_thr_q <= `LOW_THR_RESET;
            high_thr_q <= `HIGH_THR_RESET;
            agc_en_q <= 1'b1;
        end
        else if (CE)
        begin
            if (wr_pwr)
            begin
                logamp_pd_q <= wd[`LOGAMP_PD_BIT];
                shared_q <= wd[`SHARED_MATCH_BIT];
            end
            if (wr_agc)
            begin
                low_thr_q <= wd[`LOW_THR_HI:`LOW_THR_LO];
                high_thr_q <= wd[`HIGH_THR_HI:`HIGH_THR_LO];
                agc_en_q <= wd[`AGC_EN_BIT];
            end
        end
    end

    // Sequencer clock as an enable tick; divider 0 behaves as 1
    // sequencer divider
    logic [7:0] seq_cnt_q;
    logic seq_tick_q;
    wire seq_wrap = (seq_cnt_q + 8'h01 >= seq_div_q);

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            seq_cnt_q <= 8'h00;
            seq_tick_q <= 1'b0;
        end
        else if (CE)
        begin
            seq_cnt_q <= seq_wrap ? 8'h00 : seq_cnt_q + 8'h01;
            seq_tick_q <= seq_wrap;
        end
    end

    // Gain control steps once per sequencer tick in receive
    // reduced mode caps the gain step
    // top step needs the reduced bit clear
    logic [1:0] gain_q;
    logic [1:0] gain_d;
    wire [1:0] gain_max = amp_red_q ? `GAIN_REDUCED_TOP : `GAIN_TOP;
    wire agc_run = seq_tick_q && !tx_q && agc_en_q;
    wire step_up = RSSI_LEVEL < low_thr_q && gain_q < gain_max;
    wire step_dn = RSSI_LEVEL > high_thr_q && gain_q != 2'h0;

    always_comb
    begin
        gain_d = gain_q;
        if (gain_q > gain_max)
            gain_d = gain_max;
        else if (agc_run && step_up)
            gain_d = gain_q + 2'h1;
        else if (agc_run && step_dn)
            gain_d = gain_q - 2'h1;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            gain_q <= 2'h0;
        else if (CE)
            gain_q <= gain_d;
    end

    // Filter calibration; a new request restarts a running one
    // start on every write with bit set
    cfg_pkg::cal_state_t cal_q;
    logic [15:0] cal_cnt_q;
    logic cal_start_q;
    wire cal_req = wr_corr && wd[`CAL_BIT];

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cal_q <= cfg_pkg::CAL_IDLE;
            cal_cnt_q <= 16'h0000;
            cal_start_q <= 1'b0;
        end
        else if (CE)
        begin
            cal_start_q <= cal_req;
            unique case (cal_q)
                cfg_pkg::CAL_IDLE:
                begin
                    if (cal_req)
                    begin
                        cal_q <= cfg_pkg::CAL_RUN;
                        cal_cnt_q <= 16'h0000;
                    end
                end
                cfg_pkg::CAL_RUN:
                begin
                    if (cal_req)
                        cal_cnt_q <= 16'h0000;
                    else if (cal_cnt_q == `CAL_CYCLES - 16'h0001)
                        cal_q <= cfg_pkg::CAL_IDLE;
                    else
                        cal_cnt_q <= cal_cnt_q + 16'h0001;
                end
            endcase
        end
    end

    // Readback validity per source and mode
    // receive mode limits
    wire rb_rssi = rb_src_q == cfg_pkg::RB_RSSI;
    wire rb_ok_rx = rb_rssi || !agc_en_q;
    wire rb_ok_tx = !rb_rssi && !logamp_pd_q;
    logic rb_valid_q;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            rb_valid_q <= 1'b0;
        else if (CE)
            rb_valid_q <= rb_en_q && (tx_q ? rb_ok_tx : rb_ok_rx);
    end

    wire sync_en = sync_mode(sync_mode_q) && !tx_q;
    logic lock;

    sync_detect u_sync (
        .clk(CLK),
        .rst_n(RESET_N),
        .ce(CE),
        .enable(sync_en),
        .bit_in(RX_BIT),
        .bit_valid(RX_BIT_VALID),
        .pattern(sync_pat_q),
        .lock(lock)
    );

    wire long_runs = dmode_q == 3'h1 || dmode_q == 3'h3 || dmode_q == 3'h4 || dmode_q == 3'h5;

    // Status word read at its own index
    logic [31:0] status;
    assign status = {20'h00000, sync_mode(sync_mode_q), long_runs, gain_q,
        rb_valid_q, cal_q == cfg_pkg::CAL_RUN, lock, tx_q, `IDX_STATUS};

    cfg_pkg::cfg_read_t rd_req;
    assign rd_req.en = RD_EN;
    assign rd_req.idx = ADDR;
    assign rd_req.ext = (ADDR == `IDX_STATUS) ? status : 32'h00000000;

    // Reads never stall; unmapped indices answer zero
    cfg_latch_mem u_mem (
        .clk(CLK),
        .rst_n(RESET_N),
        .ce(CE),
        .wr(wr_word),
        .rd(rd_req),
        .rdata(RD_DATA)
    );

    assign TX_MODE = tx_q;
    assign ANT_SWITCH_TX = tx_q;
    assign LOCK_INT = lock;
    assign SYNC_ACTIVE = sync_en;
    assign RUNLENGTH_TOLERANT = long_runs;
    assign FILTER_CAL_START = cal_start_q;
    assign FILTER_CAL_BUSY = cal_q == cfg_pkg::CAL_RUN;
    assign SEQUENCER_TICK = seq_tick_q;
    assign LNA_GAIN = gain_q;
    assign READBACK_VALID = rb_valid_q;
    assign LOG_AMP_ON = !logamp_pd_q;
    assign SHARED_MATCH = shared_q;
endmodule

/* File: verif/host_serial_model.sv */
// Host side of the three-wire load port
`timescale 1ns/1ps
module host_serial_model (
    input logic CLK,
    output logic SCLK,
    output logic SDATA,
    output logic LOAD_STROBE
);
    initial
    begin
        SCLK = 1'b0;
        SDATA = 1'b0;
        LOAD_STROBE = 1'b0;
    end
    // Each level held two cycles so the sampled edge detector sees it
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            @(posedge CLK);
            SDATA <= w[i];
            SCLK <= 1'b0;
            repeat (2) @(posedge CLK);
            SCLK <= 1'b1;
            @(posedge CLK);
        end
        @(posedge CLK);
        SCLK <= 1'b0;
        SDATA <= ~SDATA;
        repeat (2) @(posedge CLK);
        LOAD_STROBE <= 1'b1;
        repeat (2) @(posedge CLK);
        LOAD_STROBE <= 1'b0;
        repeat (2) @(posedge CLK);
    endtask
endmodule

/* File: verif/xcvr_cfg_asserts.sv */
// Concurrent checks on the configuration block ports
`timescale 1ns/1ps
module xcvr_cfg_asserts (
    input logic CLK,
    input logic RESET_N,
    input logic CE,
    input logic LOAD_STROBE,
    input logic [3:0] ADDR,
    input logic [31:0] WR_DATA,
    input logic WR_EN,
    input logic RD_EN,
    input logic [31:0] RD_DATA,
    input logic RX_BIT_VALID,
    input logic TX_MODE,
    input logic ANT_SWITCH_TX,
    input logic LOCK_INT,
    input logic SYNC_ACTIVE,
    input logic FILTER_CAL_START,
    input logic FILTER_CAL_BUSY,
    input logic SEQUENCER_TICK,
    input logic [1:0] LNA_GAIN,
    input logic READBACK_VALID,
    input logic LOG_AMP_ON,
    input logic SHARED_MATCH
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    // Counts data bits seen while the lock output is high
    logic [3:0] lock_bits_q;
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            lock_bits_q <= 4'h0;
        else if (!LOCK_INT)
            lock_bits_q <= 4'h0;
        else if (CE && RX_BIT_VALID)
            lock_bits_q <= lock_bits_q + 4'h1;
    end
    // Reduced gain bit as last written over the port; serial loads are not tracked
    logic reduced_q;
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            reduced_q <= 1'b0;
        else if (CE && WR_EN && !LOAD_STROBE && ADDR == 4'h6)
            reduced_q <= WR_DATA[15];
    end
    chk_reduced_cap: assert property (reduced_q |=> LNA_GAIN != 2'h3)
        else $error("top gain step in reduced mode");
    chk_tx_ant_match: assert property (ANT_SWITCH_TX == TX_MODE)
        else $error("antenna switch disagrees with mode");
    chk_read_idle: assert property (!$past(RD_EN) |-> RD_DATA == 32'h0)
        else $error("read data outside read slot");
    chk_cal_kick: assert property (
        CE && WR_EN && !LOAD_STROBE && ADDR == 4'h6 && WR_DATA[19] |=> FILTER_CAL_START)
        else $error("calibration not started");
    chk_cal_busy: assert property ($rose(FILTER_CAL_START) |=> FILTER_CAL_BUSY [*8])
        else $error("calibration busy missing");
    chk_lock_cause: assert property (
        $rose(LOCK_INT) |-> $past(SYNC_ACTIVE) && $past(RX_BIT_VALID))
        else $error("lock without sync match");
    chk_lock_span: assert property ($fell(LOCK_INT) && SYNC_ACTIVE |-> lock_bits_q == 4'h9)
        else $error("lock length not nine bits");
    chk_gain_step: assert property ($changed(LNA_GAIN) |->
        $past(SEQUENCER_TICK) || ($past(LNA_GAIN) == 2'h3 && LNA_GAIN == 2'h2))
        else $error("gain moved off a tick");
    chk_reset_state: assert property (
        $rose(RESET_N) |-> LOG_AMP_ON && !SHARED_MATCH && !TX_MODE && !LOCK_INT)
        else $error("bad state after reset");
    chk_rb_txlog: assert property (
        READBACK_VALID && TX_MODE && $stable(TX_MODE) && $stable(LOG_AMP_ON) |-> LOG_AMP_ON)
        else $error("tx readback valid with log amp off");
endmodule
bind xcvr_cfg xcvr_cfg_asserts chk (
    .CLK, .RESET_N, .CE, .LOAD_STROBE, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA,
    .RX_BIT_VALID, .TX_MODE, .ANT_SWITCH_TX, .LOCK_INT, .SYNC_ACTIVE, .FILTER_CAL_START,
    .FILTER_CAL_BUSY, .SEQUENCER_TICK, .LNA_GAIN, .READBACK_VALID, .LOG_AMP_ON, .SHARED_MATCH
);

/* File: verif/xcvr_cfg_tb.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module xcvr_cfg_tb;
    logic CLK, RESET_N, SCLK, SDATA, LOAD_STROBE, WR_EN, RD_EN, RX_BIT, RX_BIT_VALID;
    logic [3:0] ADDR;
    logic [31:0] WR_DATA, RD_DATA;
    logic [6:0] RSSI_LEVEL;
    logic [1:0] LNA_GAIN;
    logic TX_MODE, ANT_SWITCH_TX, LOCK_INT, SYNC_ACTIVE, RUNLENGTH_TOLERANT;
    logic FILTER_CAL_START, FILTER_CAL_BUSY, SEQUENCER_TICK, READBACK_VALID;
    logic LOG_AMP_ON, SHARED_MATCH;
    int failures = 0;
    int check_count = 0;
    xcvr_cfg dut (
        .CLK, .RESET_N, .CE(1'b1), .SCLK, .SDATA, .LOAD_STROBE, .ADDR, .WR_DATA, .WR_EN,
        .RD_EN, .RD_DATA, .RX_BIT, .RX_BIT_VALID, .RSSI_LEVEL, .TX_MODE, .ANT_SWITCH_TX,
        .LOCK_INT, .SYNC_ACTIVE, .RUNLENGTH_TOLERANT, .FILTER_CAL_START, .FILTER_CAL_BUSY,
        .SEQUENCER_TICK, .LNA_GAIN, .READBACK_VALID, .LOG_AMP_ON, .SHARED_MATCH
    );
    host_serial_model host (.CLK, .SCLK, .SDATA, .LOAD_STROBE);
    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        WR_EN <= 1'b1;
        ADDR <= a;
        WR_DATA <= d;
        @(posedge CLK);
        WR_EN <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge CLK);
        RD_EN <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD_EN <= 1'b0;
        #1 check(RD_DATA, e);
    endtask
    task automatic rx_bit(input logic b);
        @(posedge CLK);
        RX_BIT <= b;
        RX_BIT_VALID <= 1'b1;
        @(posedge CLK);
        RX_BIT_VALID <= 1'b0;
    endtask
    task automatic t_defaults;
        rd(4'hF, 32'h0000000F);
        rd(4'h9, 32'h000631E9);
        rd(4'h8, 32'h00000008);
        wr(4'hC, 32'hFFFFFFFF);
        rd(4'hC, 32'h0);
        check(LOG_AMP_ON, 1'b1);
        $display("defaults done");
    endtask
    task automatic t_serial;
        host.send(32'h08000000);
        check(TX_MODE, 1'b1);
        check(ANT_SWITCH_TX, 1'b1);
        host.send(32'h1234567B);
        rd(4'h0, 32'h08000000);
        host.send(32'h0A5C3F15);
        rd(4'h5, 32'h0A5C3F15);
        wr(4'h0, 32'h0);
        $display("serial done");
    endtask
    task automatic t_modes;
        for (int m = 0; m < 8; m++)
        begin
            wr(4'h4, {6'h0, m[2:0], 16'h0, m[2:0], 4'h4});
            #1 check(SYNC_ACTIVE, m == 2 || m == 3);
            check(RUNLENGTH_TOLERANT, m inside {1, 3, 4, 5});
        end
        $display("modes done");
    endtask
    task automatic t_lock;
        logic [23:0] pat;
        pat = 24'hA5C3F1;
        wr(4'h4, 32'h01000004);
        for (int i = 23; i >= 0; i--)
        begin
            rx_bit(pat[i]);
            #1 check(LOCK_INT, i == 0);
        end
        for (int i = 1; i <= 9; i++)
        begin
            rx_bit(1'b0);
            #1 check(LOCK_INT, i < 9);
        end
        wr(4'h4, 32'h00000004);
        $display("lock done");
    endtask
    task automatic t_cal;
        wr(4'h6, 32'h00080006);
        #1 check(FILTER_CAL_START, 1'b1);
        repeat (100) @(posedge CLK);
        wr(4'h6, 32'h00080006);
        repeat (1000) @(posedge CLK);
        #1 check(FILTER_CAL_BUSY, 1'b1);
        repeat (30) @(posedge CLK);
        #1 check(FILTER_CAL_BUSY, 1'b0);
        wr(4'h6, 32'h00000006);
        #1 check(FILTER_CAL_START, 1'b0);
        $display("calibration done");
    endtask
    task automatic t_gain;
        int ticks;
        ticks = 0;
        wr(4'h3, 32'h00000203);
        RSSI_LEVEL <= 7'h00;
        repeat (20)
        begin
            @(posedge CLK);
            #1 ticks += SEQUENCER_TICK;
        end
        check(ticks, 10);
        check(LNA_GAIN, 2'h3);
        wr(4'h6, 32'h00008006);
        RSSI_LEVEL <= 7'h46;
        repeat (20) @(posedge CLK);
        #1 check(LNA_GAIN, 2'h2);
        @(posedge CLK);
        RSSI_LEVEL <= 7'h47;
        repeat (20) @(posedge CLK);
        #1 check(LNA_GAIN, 2'h0);
        wr(4'h6, 32'h00000006);
        $display("gain done");
    endtask
    task automatic t_readback;
        wr(4'h7, 32'h00000107);
        @(posedge CLK);
        #1 check(READBACK_VALID, 1'b1);
        wr(4'h7, 32'h00000117);
        @(posedge CLK);
        #1 check(READBACK_VALID, 1'b0);
        wr(4'h0, 32'h08000000);
        @(posedge CLK);
        #1 check(READBACK_VALID, 1'b1);
        wr(4'h8, 32'h00000408);
        @(posedge CLK);
        #1 check(READBACK_VALID, 1'b0);
        check(LOG_AMP_ON, 1'b0);
        wr(4'h8, 32'h00001008);
        #1 check(SHARED_MATCH, 1'b1);
        wr(4'h0, 32'h0);
        $display("readback done");
    endtask
    task automatic t_agc;
        wr(4'h9, 32'h000678F9);
        RSSI_LEVEL <= 7'h14;
        repeat (20) @(posedge CLK);
        #1 check(LNA_GAIN, 2'h0);
        @(posedge CLK);
        RSSI_LEVEL <= 7'h0E;
        repeat (20) @(posedge CLK);
        #1 check(LNA_GAIN, 2'h3);
        @(posedge CLK);
        RSSI_LEVEL <= 7'h4B;
        repeat (20) @(posedge CLK);
        #1 check(LNA_GAIN, 2'h3);
        @(posedge CLK);
        RSSI_LEVEL <= 7'h50;
        repeat (20) @(posedge CLK);
        #1 check(LNA_GAIN, 2'h0);
        rd(4'h9, 32'h000678F9);
        wr(4'h9, 32'h000278F9);
        @(posedge CLK);
        #1 check(READBACK_VALID, 1'b1);
        wr(4'hA, 32'h0000357A);
        rd(4'hA, 32'h0000357A);
        $display("agc done");
    endtask
    initial
    begin
        RESET_N = 1'b0;
        WR_EN = 1'b0;
        RD_EN = 1'b0;
        ADDR = 4'h0;
        WR_DATA = 32'h0;
        RX_BIT = 1'b0;
        RX_BIT_VALID = 1'b0;
        RSSI_LEVEL = 7'h28;
        repeat (5) @(posedge CLK);
        RESET_N <= 1'b1;
        t_defaults();
        t_serial();
        t_modes();
        t_lock();
        t_cal();
        t_gain();
        t_readback();
        t_agc();
        stop_test();
    end
    // Whole run needs about 1800 cycles
    initial
    begin
        #80000;
        failures++;
        stop_test();
    end
endmodule
